// ===== hw/tmr_ioc_pkg.sv
// Shared constants and types for the timer pin I/O control decoder.
package tmr_ioc_pkg;

   // Channel slots handled by the decoder.
   localparam int NCH   = 4;
   localparam int CW    = 16;
   localparam int CH_B4 = 0;
   localparam int CH_B5 = 1;
   localparam int CH_A0 = 2;
   localparam int CH_D3 = 3;

   // APB register byte offsets.
   localparam int         AW            = 8;
   localparam logic [7:0] OFS_IOC_CH4   = 8'h00;
   localparam logic [7:0] OFS_IOC_CH5   = 8'h04;
   localparam logic [7:0] OFS_IOC_H_CH0 = 8'h08;
   localparam logic [7:0] OFS_IOC_L_CH3 = 8'h0c;
   localparam logic [7:0] OFS_CTL_CH4   = 8'h10;
   localparam logic [7:0] OFS_MODE_CH3  = 8'h14;
   localparam logic [7:0] OFS_GR_B4     = 8'h18;
   localparam logic [7:0] OFS_GR_B5     = 8'h1c;
   localparam logic [7:0] OFS_GR_A0     = 8'h20;
   localparam logic [7:0] OFS_GR_D3     = 8'h24;
   localparam logic [7:0] OFS_STATUS    = 8'h28;
   localparam logic [7:0] OFS_FLAGS     = 8'h2c;

   // Reset values.
   localparam logic [7:0]  IOC_RST  = 8'h00;
   localparam logic [2:0]  CTL_RST  = 3'h0;
   localparam logic [7:0]  MODE_RST = 8'h00;
   localparam logic [15:0] GR_RST   = 16'hffff;

   // Field layout.
   localparam int FW         = 4;
   localparam int FLD_HI_LSB = 4;
   localparam int FLD_LO_LSB = 0;
   localparam int PSC_W      = 3;
   localparam int BUFD_BIT   = 5;
   localparam int FB_CAP     = 3;
   localparam int FB_LVL     = 2;
   localparam int FB_SRC     = 2;
   localparam int FB_BOTH    = 1;
   localparam int FB_FALL    = 0;

   // Codes.
   localparam logic [2:0] PSC_UNDIV = 3'h0;
   localparam logic [1:0] ACT_OFF   = 2'h0;
   localparam logic [1:0] ACT_LOW   = 2'h1;
   localparam logic [1:0] ACT_HIGH  = 2'h2;
   localparam logic [1:0] ACT_TOG   = 2'h3;

   typedef enum logic [2:0] {
      MODE_OFF = 3'b001,
      MODE_CMP = 3'b010,
      MODE_CAP = 3'b100
   } chan_mode_t;

   typedef struct packed {
      logic          pin;
      logic [CW-1:0] count;
   } chan_ext_t;

   typedef struct packed {
      logic pin;
      logic oe;
      logic match;
      logic capture;
   } chan_out_t;

endpackage

// ===== hw/chan_io_unit.sv
// One channel's pin I/O control decode: compare action or capture trigger.
`timescale 1ns/1ps
`default_nettype none

module chan_io_unit #(
   parameter int CW          = 16,
   parameter bit HAS_CASCADE = 1'b1
) (
   // Clock and reset.
   input  wire logic                   core_clk_i,
   input  wire logic                   nrst_i,
   // Control field.
   input  wire logic [3:0]             field_i,
   input  wire logic                   field_load_i,
   input  wire logic                   inhibit_i,
   // Timer side.
   input  wire tmr_ioc_pkg::chan_ext_t ext_i,
   input  wire logic [CW-1:0]          gr_i,
   input  wire logic                   cascade_i,
   // Result.
   output tmr_ioc_pkg::chan_out_t      out_o
);
   import tmr_ioc_pkg::*;

   chan_mode_t mode;
   logic       pin_reg;
   logic       pin_next;
   logic       prev_reg;
   logic       rise;
   logic       fall;
   logic       pin_trig;
   logic       cas_sel;
   logic       match;

   always_comb begin
      if (inhibit_i) begin
         mode = MODE_OFF;
      end else if (field_i[FB_CAP]) begin
         mode = MODE_CAP;
      end else if (field_i[1:0] == ACT_OFF) begin
         mode = MODE_OFF;
      end else begin
         mode = MODE_CMP;
      end
   end

   assign match = (mode == MODE_CMP) && (ext_i.count == gr_i);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= ext_i.pin;
      end
   end

   assign rise    = ext_i.pin & ~prev_reg;
   assign fall    = ~ext_i.pin & prev_reg;
   assign cas_sel = HAS_CASCADE && field_i[FB_SRC];

   always_comb begin
      if (field_i[FB_BOTH]) begin
         pin_trig = rise | fall;
      end else if (field_i[FB_FALL]) begin
         pin_trig = fall;
      end else begin
         pin_trig = rise;
      end
   end

   always_comb begin
      pin_next = pin_reg;
      if (field_load_i) begin
         pin_next = field_i[FB_LVL];
      end else if (match) begin
         case (field_i[1:0])
            ACT_LOW:  pin_next = 1'b0;
            ACT_HIGH: pin_next = 1'b1;
            ACT_TOG:  pin_next = ~pin_reg;
            default:  pin_next = pin_reg;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= pin_next;
      end
   end

   assign out_o.pin     = pin_reg;
   assign out_o.oe      = (mode == MODE_CMP);
   assign out_o.match   = match;
   assign out_o.capture = (mode == MODE_CAP) && (cas_sel ? cascade_i : pin_trig);

endmodule

`default_nettype wire

// ===== hw/timer_pin_io_control_decode.sv
// Top of the timer pin I/O control decoder with its APB register file.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module timer_pin_io_control_decode (
   // Clock and reset.
   input  wire logic                      core_clk_i,
   input  wire logic                      nrst_i,
   // APB slave.
   input  wire logic [tmr_ioc_pkg::AW-1:0] paddr_i,
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [31:0]               pwdata_i,
   input  wire logic [3:0]                pstrb_i,
   output logic                           pready_o,
   output logic [31:0]                    prdata_o,
   output logic                           pslverr_o,
   // Channel counters.
   input  wire logic [15:0]               counter_ch4_i,
   input  wire logic [15:0]               counter_ch5_i,
   input  wire logic [15:0]               counter_ch0_i,
   input  wire logic [15:0]               counter_ch3_i,
   // Cascade sources from neighbouring channels.
   input  wire logic                      ch3c_event_i,
   input  wire logic                      counter_ch1_step_i,
   input  wire logic                      counter_ch4_step_i,
   // Channel 4 B pin.
   input  wire logic                      pin_b_ch4_i,
   output logic                           pin_b_ch4_o,
   output logic                           pin_b_ch4_oe_o,
   // Channel 5 B pin.
   input  wire logic                      pin_b_ch5_i,
   output logic                           pin_b_ch5_o,
   output logic                           pin_b_ch5_oe_o,
   // Channel 0 A pin.
   input  wire logic                      pin_a_ch0_i,
   output logic                           pin_a_ch0_o,
   output logic                           pin_a_ch0_oe_o,
   // Channel 3 D pin.
   input  wire logic                      pin_d_ch3_i,
   output logic                           pin_d_ch3_o,
   output logic                           pin_d_ch3_oe_o,
   // Per-channel event pulses, bit order B4, B5, A0, D3.
   output logic [3:0]                     match_o,
   output logic [3:0]                     capture_o
);
   import tmr_ioc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [7:0]       ioc_reg [NCH];
   logic [CW-1:0]    gr_reg [NCH];
   logic [PSC_W-1:0] ctl_ch4_reg;
   logic [7:0]       mode_ch3_reg;
   logic [NCH-1:0]   cap_flag_reg;
   logic [NCH-1:0]   match_flag_reg;
   logic [31:0]      rdata_reg;
   logic             rerr_reg;

   logic [31:0]      rdata_next;
   logic             rerr_next;
   logic             setup;
   logic             access;
   logic             wr_en;
   logic             hit_ioc;
   logic             hit_gr;
   logic             hit_ctl;
   logic             hit_mode;
   logic             hit_status;
   logic             hit_flags;
   logic [1:0]       sel_idx;

   logic [3:0]       field [NCH];
   logic [3:0]       field_sel [NCH];
   logic [NCH-1:0]   field_load;
   logic [NCH-1:0]   inhibit;
   logic [NCH-1:0]   cascade;
   logic [NCH-1:0]   gr_write;
   chan_ext_t        ext [NCH];
   chan_out_t        res [NCH];
   logic [NCH-1:0]   pin_lvl;
   logic [NCH-1:0]   pin_oe;

   ////////////////////////////////////////////////////////////////////////
   // APB phase and address decode.

   // Only the access phase of a write changes a register.
   assign setup    = psel_i & ~penable_i;
   assign access   = psel_i & penable_i;
   assign wr_en    = access & pwrite_i;
   assign pready_o = 1'b1;
   assign prdata_o = rdata_reg;
   assign pslverr_o = rerr_reg;

   always_comb begin
      hit_ioc    = 1'b0;
      hit_gr     = 1'b0;
      hit_ctl    = 1'b0;
      hit_mode   = 1'b0;
      hit_status = 1'b0;
      hit_flags  = 1'b0;
      sel_idx    = 2'h0;
      if (paddr_i == OFS_IOC_CH4) begin
         hit_ioc = 1'b1;
         sel_idx = 2'(CH_B4);
      end else if (paddr_i == OFS_IOC_CH5) begin
         hit_ioc = 1'b1;
         sel_idx = 2'(CH_B5);
      end else if (paddr_i == OFS_IOC_H_CH0) begin
         hit_ioc = 1'b1;
         sel_idx = 2'(CH_A0);
      end else if (paddr_i == OFS_IOC_L_CH3) begin
         hit_ioc = 1'b1;
         sel_idx = 2'(CH_D3);
      end else if (paddr_i == OFS_CTL_CH4) begin
         hit_ctl = 1'b1;
      end else if (paddr_i == OFS_MODE_CH3) begin
         hit_mode = 1'b1;
      end else if (paddr_i == OFS_GR_B4) begin
         hit_gr  = 1'b1;
         sel_idx = 2'(CH_B4);
      end else if (paddr_i == OFS_GR_B5) begin
         hit_gr  = 1'b1;
         sel_idx = 2'(CH_B5);
      end else if (paddr_i == OFS_GR_A0) begin
         hit_gr  = 1'b1;
         sel_idx = 2'(CH_A0);
      end else if (paddr_i == OFS_GR_D3) begin
         hit_gr  = 1'b1;
         sel_idx = 2'(CH_D3);
      end else if (paddr_i == OFS_STATUS) begin
         hit_status = 1'b1;
      end else if (paddr_i == OFS_FLAGS) begin
         hit_flags = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup phase and held through access.

   always_comb begin
      rdata_next = 32'h0000_0000;
      rerr_next  = 1'b0;
      if (hit_ioc) begin
         rdata_next[7:0] = ioc_reg[sel_idx];
      end else if (hit_gr) begin
         rdata_next[CW-1:0] = gr_reg[sel_idx];
      end else if (hit_ctl) begin
         rdata_next[PSC_W-1:0] = ctl_ch4_reg;
      end else if (hit_mode) begin
         rdata_next[7:0] = mode_ch3_reg;
      end else if (hit_status) begin
         rdata_next[2*NCH-1:0] = {pin_oe, pin_lvl};
      end else if (hit_flags) begin
         rdata_next[2*NCH-1:0] = {match_flag_reg, cap_flag_reg};
      end else begin
         rerr_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (setup) begin
         rdata_reg <= pwrite_i ? 32'h0000_0000 : rdata_next;
      end
   end

   // The error flag follows the address of the same setup phase.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rerr_reg <= 1'b0;
      end else if (setup) begin
         rerr_reg <= rerr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared control registers.

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctl_ch4_reg <= CTL_RST;
      end else if (wr_en && hit_ctl && pstrb_i[0]) begin
         ctl_ch4_reg <= pwdata_i[PSC_W-1:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_ch3_reg <= MODE_RST;
      end else if (wr_en && hit_mode && pstrb_i[0]) begin
         mode_ch3_reg <= pwdata_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky event flags; a new event wins over a write-one clear.

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cap_flag_reg <= '0;
      end else if (wr_en && hit_flags && pstrb_i[0]) begin
         cap_flag_reg <= (cap_flag_reg & ~pwdata_i[NCH-1:0]) | capture_o;
      end else begin
         cap_flag_reg <= cap_flag_reg | capture_o;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         match_flag_reg <= '0;
      end else if (wr_en && hit_flags && pstrb_i[0]) begin
         match_flag_reg <= (match_flag_reg & ~pwdata_i[2*NCH-1:NCH]) | match_o;
      end else begin
         match_flag_reg <= match_flag_reg | match_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cascade sources and suppression.

   assign cascade[CH_B4] = ch3c_event_i;
   assign cascade[CH_B5] = 1'b0;
   assign cascade[CH_A0] = counter_ch1_step_i;
   assign cascade[CH_D3] = counter_ch4_step_i && (ctl_ch4_reg != PSC_UNDIV);

   assign inhibit[CH_B4] = 1'b0;
   assign inhibit[CH_B5] = 1'b0;
   assign inhibit[CH_A0] = 1'b0;
   assign inhibit[CH_D3] = mode_ch3_reg[BUFD_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Timer side inputs.

   assign ext[CH_B4].pin   = pin_b_ch4_i;
   assign ext[CH_B4].count = counter_ch4_i;
   assign ext[CH_B5].pin   = pin_b_ch5_i;
   assign ext[CH_B5].count = counter_ch5_i;
   assign ext[CH_A0].pin   = pin_a_ch0_i;
   assign ext[CH_A0].count = counter_ch0_i;
   assign ext[CH_D3].pin   = pin_d_ch3_i;
   assign ext[CH_D3].count = counter_ch3_i;

   ////////////////////////////////////////////////////////////////////////
   // Per-channel registers and decode.

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      localparam int  LSB = (g == CH_A0) ? FLD_LO_LSB : FLD_HI_LSB;
      localparam bit  CAS = (g != CH_B5);
      logic [1:0]     gidx;

      assign gidx          = 2'(g);
      assign field[g]      = ioc_reg[g][LSB +: FW];
      assign field_load[g] = wr_en && hit_ioc && (sel_idx == gidx) && pstrb_i[0];
      assign gr_write[g]   = wr_en && hit_gr && (sel_idx == gidx);

      // The new field acts already in the cycle in which it is written.
      always_comb begin
         field_sel[g] = field[g];
         if (field_load[g]) begin
            field_sel[g] = pwdata_i[LSB +: FW];
         end
      end

      always_ff @(posedge core_clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            ioc_reg[g] <= IOC_RST;
         end else if (field_load[g]) begin
            ioc_reg[g] <= pwdata_i[7:0];
         end
      end

      // A capture wins over a software write in the same cycle.
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            gr_reg[g] <= GR_RST;
         end else if (res[g].capture) begin
            gr_reg[g] <= ext[g].count;
         end else if (gr_write[g]) begin
            if (pstrb_i[0]) begin
               gr_reg[g][7:0] <= pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
               gr_reg[g][15:8] <= pwdata_i[15:8];
            end
         end
      end

      chan_io_unit #(
         .CW          (CW),
         .HAS_CASCADE (CAS)
      ) chan_io_unit_inst (
         .core_clk_i   (core_clk_i),
         .nrst_i       (nrst_i),
         .field_i      (field_sel[g]),
         .field_load_i (field_load[g]),
         .inhibit_i    (inhibit[g]),
         .ext_i        (ext[g]),
         .gr_i         (gr_reg[g]),
         .cascade_i    (cascade[g]),
         .out_o        (res[g])
      );

      assign pin_lvl[g]   = res[g].pin;
      assign pin_oe[g]    = res[g].oe;
      assign match_o[g]   = res[g].match;
      assign capture_o[g] = res[g].capture;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs.

   assign pin_b_ch4_o    = pin_lvl[CH_B4];
   assign pin_b_ch4_oe_o = pin_oe[CH_B4];
   assign pin_b_ch5_o    = pin_lvl[CH_B5];
   assign pin_b_ch5_oe_o = pin_oe[CH_B5];
   assign pin_a_ch0_o    = pin_lvl[CH_A0];
   assign pin_a_ch0_oe_o = pin_oe[CH_A0];
   assign pin_d_ch3_o    = pin_lvl[CH_D3];
   assign pin_d_ch3_oe_o = pin_oe[CH_D3];

endmodule

`default_nettype wire

// ===== bench/tmr_ioc_assertions.sv
// Checker of pin and capture timing at the decoder's top ports.
`timescale 1ns/1ps
`default_nettype none
module tmr_ioc_checker (
   // Clock, reset and bus.
   input wire logic                        core_clk_i,
   input wire logic                        nrst_i,
   input wire logic                        psel_i,
   input wire logic                        penable_i,
   input wire logic                        pwrite_i,
   // Timer side.
   input wire logic                        ch3c_event_i,
   input wire logic                        counter_ch1_step_i,
   input wire logic                        counter_ch4_step_i,
   input wire logic                        pin_b_ch4_i,
   input wire logic                        pin_b_ch5_i,
   input wire logic                        pin_a_ch0_i,
   input wire logic                        pin_d_ch3_i,
   input wire logic                        pin_b_ch4_o,
   input wire logic                        pin_b_ch5_o,
   input wire logic                        pin_a_ch0_o,
   input wire logic                        pin_d_ch3_o,
   input wire logic [3:0]                  match_o,
   input wire logic [3:0]                  capture_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   a_mode_excl: assert property ((match_o & capture_o) == 4'h0)
      else $error("match and capture together");
   a_b4_pin_hold: assert property ($changed(pin_b_ch4_o) |->
      $past(match_o[0]) || $past(psel_i && penable_i && pwrite_i)) else $error("b4 pin moved");
   a_b5_pin_hold: assert property ($changed(pin_b_ch5_o) |->
      $past(match_o[1]) || $past(psel_i && penable_i && pwrite_i)) else $error("b5 pin moved");
   a_a0_pin_hold: assert property ($changed(pin_a_ch0_o) |->
      $past(match_o[2]) || $past(psel_i && penable_i && pwrite_i)) else $error("a0 pin moved");
   a_d3_pin_hold: assert property ($changed(pin_d_ch3_o) |->
      $past(match_o[3]) || $past(psel_i && penable_i && pwrite_i)) else $error("d3 pin moved");
   a_b5_cap_src: assert property (capture_o[1] |-> $changed(pin_b_ch5_i))
      else $error("b5 capture without edge");
   a_a0_cap_src: assert property (capture_o[2] |-> $changed(pin_a_ch0_i) || counter_ch1_step_i)
      else $error("a0 capture without source");
   a_b4_cap_src: assert property (capture_o[0] |-> $changed(pin_b_ch4_i) || ch3c_event_i)
      else $error("b4 capture without source");
   a_d3_cap_src: assert property (capture_o[3] |-> $changed(pin_d_ch3_i) || counter_ch4_step_i)
      else $error("d3 capture without source");
endmodule
bind timer_pin_io_control_decode tmr_ioc_checker tmr_ioc_checker_inst (.core_clk_i, .nrst_i,
   .psel_i, .penable_i, .pwrite_i, .ch3c_event_i, .counter_ch1_step_i, .counter_ch4_step_i,
   .pin_b_ch4_i, .pin_b_ch5_i, .pin_a_ch0_i, .pin_d_ch3_i, .pin_b_ch4_o, .pin_b_ch5_o,
   .pin_a_ch0_o, .pin_d_ch3_o, .match_o, .capture_o);
`default_nettype wire

// ===== bench/timer_far_model.sv
// Far-side model: one running counter shared by all channels, its count step and resolved pin wires.
`timescale 1ns/1ps
`default_nettype none
module timer_far_model (
   // Clock and reset.
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   // Bench control.
   input  wire logic        run_i,
   input  wire logic [3:0]  ext_lvl_i,
   // Device pin drive.
   input  wire logic [3:0]  pin_o_i,
   input  wire logic [3:0]  pin_oe_i,
   // Far-side view.
   output logic [15:0]      count_o,
   output logic             step_o,
   output logic [3:0]       pin_wire_o
);
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_o <= 16'h0000;
      end else if (run_i) begin
         count_o <= count_o + 16'h0001;
      end
   end
   // A count clock step is seen in every cycle the counters move.
   assign step_o = run_i;
   // The device drive wins over the outside level while enabled.
   assign pin_wire_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_lvl_i);
endmodule
`default_nettype wire

// ===== bench/timer_pin_io_control_decode_test.sv
// Self-checking bench for the timer pin I/O control decoder.
`timescale 1ns/1ps
`default_nettype none
module timer_pin_io_control_decode_test;
   import tmr_ioc_pkg::*;
   logic        core_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic        ch3c_event_i, run, step, rerr;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o, rdat;
   logic [15:0] cnt;
   logic [3:0]  ext, po, poe, pw, match_o, capture_o;
   int          bad_count, n_checks;

   timer_pin_io_control_decode timer_pin_io_control_decode_inst (.core_clk_i, .nrst_i,
      .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .pstrb_i(4'hf), .pready_o,
      .prdata_o, .pslverr_o, .counter_ch4_i(cnt), .counter_ch5_i(cnt), .counter_ch0_i(cnt),
      .counter_ch3_i(cnt), .ch3c_event_i, .counter_ch1_step_i(step), .counter_ch4_step_i(step),
      .pin_b_ch4_i(pw[0]), .pin_b_ch4_o(po[0]), .pin_b_ch4_oe_o(poe[0]),
      .pin_b_ch5_i(pw[1]), .pin_b_ch5_o(po[1]), .pin_b_ch5_oe_o(poe[1]),
      .pin_a_ch0_i(pw[2]), .pin_a_ch0_o(po[2]), .pin_a_ch0_oe_o(poe[2]),
      .pin_d_ch3_i(pw[3]), .pin_d_ch3_o(po[3]), .pin_d_ch3_oe_o(poe[3]), .match_o, .capture_o);
   timer_far_model timer_far_model_inst (.core_clk_i, .nrst_i, .run_i(run), .ext_lvl_i(ext),
      .pin_o_i(po), .pin_oe_i(poe), .count_o(cnt), .step_o(step), .pin_wire_o(pw));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic hang(input string m);
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
      close_out();
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge core_clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      paddr_i   <= a;
      pwrite_i  <= w;
      pwdata_i  <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk_i);
         if (pready_o === 1'b1) break;
      end
      if (i == 16) hang("no ready");
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      #1;
   endtask
   // Reset values and the error answer of an unmapped address.
   task automatic t_rst();
      xfer(8'h00, 1'b0, 32'h0);
      chk(rdat, 32'(IOC_RST), "control reset");
      chk(32'(rerr), 32'h0, "mapped read error");
      xfer(8'h18, 1'b0, 32'h0);
      chk(rdat, 32'(GR_RST), "register reset");
      xfer(8'h30, 1'b0, 32'h0);
      chk(rdat, 32'h0, "unmapped read data");
      chk(32'(rerr), 32'h1, "unmapped read error");
      $display("reset done");
   endtask
   // Compare codes: initial level, enable, then the level after one match.
   task automatic t_cmp(input int b, input logic [7:0] a, input int sh, input logic [7:0] g);
      logic [3:0] c;
      int i;
      for (int k = 0; k < 8; k++) begin
         c = k[3:0];
         xfer(a, 1'b1, 32'(c) << sh);
         chk(po[b], c[2], "initial level");
         chk(poe[b], c[1:0] != 2'b00, "output enable");
         if (c[1:0] != 2'b00) begin
            xfer(g, 1'b1, {16'h0000, cnt + 16'h0010});
            for (i = 0; i < 64 && match_o[b] !== 1'b1; i++) begin
               @(posedge core_clk_i);
               #1;
            end
            if (i == 64) hang("no match");
            @(posedge core_clk_i);
            #1;
            chk(po[b], c[1:0] == 2'b11 ? !c[2] : c[1], "level after match");
         end
      end
      $display("compare done on slot %0d", b);
   endtask
   // Capture codes: one rising and one falling pin edge, captured count read back.
   task automatic t_cap(input int b, input logic [7:0] a, input int sh, input logic [7:0] g,
                        input logic [3:0] c);
      logic [15:0] v;
      for (int e = 1; e >= 0; e--) begin
         xfer(a, 1'b1, 32'(c) << sh);
         @(posedge core_clk_i);
         ext[b] <= e[0];
         #1;
         v = cnt;
         chk(capture_o[b], e ? (!c[0] || c[1]) : (c[0] || c[1]), "capture edge");
         if (capture_o[b] === 1'b1) begin
            xfer(g, 1'b0, 32'h0);
            chk(rdat, {16'h0000, v}, "captured count");
         end
      end
      $display("capture done on slot %0d code %0h", b, c);
   endtask
   task automatic t_casc();
      int i;
      xfer(8'h10, 1'b1, 32'h1);
      xfer(8'h00, 1'b1, 32'hc0);
      @(posedge core_clk_i);
      ch3c_event_i <= 1'b1;
      #1;
      chk(capture_o[0], 1'b1, "cascade capture");
      @(posedge core_clk_i);
      ch3c_event_i <= 1'b0;
      ext[0]       <= !ext[0];
      #1;
      chk(capture_o[0], 1'b0, "pin ignored in cascade");
      xfer(8'h08, 1'b1, 32'hc);
      chk(capture_o[2], 1'b1, "count step capture");
      @(posedge core_clk_i);
      run <= 1'b0;
      #1;
      chk(capture_o[2], 1'b0, "no step no capture");
      @(posedge core_clk_i);
      run <= 1'b1;
      xfer(8'h0c, 1'b1, 32'hc0);
      chk(capture_o[3], 1'b1, "divided clock capture");
      xfer(8'h10, 1'b1, 32'h0);
      chk(capture_o[3], 1'b0, "undivided clock capture");
      xfer(8'h14, 1'b1, 32'h20);
      xfer(8'h0c, 1'b1, 32'h20);
      chk(poe[3], 1'b0, "buffer mode enable");
      xfer(8'h24, 1'b1, {16'h0000, cnt + 16'h0008});
      for (i = 0; i < 32; i++) begin
         @(posedge core_clk_i);
         #1;
         chk(match_o[3] | capture_o[3], 1'b0, "buffer mode event");
      end
      xfer(8'h14, 1'b1, 32'h0);
      chk(poe[3], 1'b1, "compare back");
      $display("cascade done");
   endtask
   // Status view and sticky flags; a live capture outlasts its own clear.
   task automatic t_flags();
      xfer(8'h28, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0087, "status view");
      xfer(8'h2c, 1'b0, 32'h0);
      chk(rdat, 32'h0000_005f, "event flags");
      xfer(8'h2c, 1'b1, 32'h0000_00ff);
      xfer(8'h2c, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0004, "flags after clear");
      $display("flags done");
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = !core_clk_i;
   end
   initial begin
      nrst_i = 1'b0;
      {psel_i, penable_i, pwrite_i, ch3c_event_i, run} = '0;
      paddr_i  = 8'h00;
      pwdata_i = 32'h0;
      ext      = 4'h0;
      repeat (10) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      run    <= 1'b1;
      t_rst();
      t_cmp(0, 8'h00, 4, 8'h18);
      t_cmp(2, 8'h08, 0, 8'h20);
      t_cap(1, 8'h04, 4, 8'h1c, 4'h8);
      t_cap(1, 8'h04, 4, 8'h1c, 4'h9);
      t_cap(1, 8'h04, 4, 8'h1c, 4'ha);
      t_cap(1, 8'h04, 4, 8'h1c, 4'hc);
      t_cap(2, 8'h08, 0, 8'h20, 4'h8);
      t_cap(2, 8'h08, 0, 8'h20, 4'hb);
      t_casc();
      t_flags();
      close_out();
   end
   initial begin
      #500000;
      hang("run too long");
   end
endmodule
`default_nettype wire
